// [hw/fpw_pkg.sv]
package fpw_pkg;

  // Register indices; the host port addresses 16-bit registers directly
  localparam logic [7:0]  FPW_ADDR_LOW      = 8'h00;
  localparam logic [7:0]  FPW_ADDR_HIGH     = 8'h01;

  localparam int          FPW_WORD_W        = 26;
  localparam int          FPW_LOW_W         = 16;
  localparam int          FPW_HIGH_W        = 10;
  localparam int          FPW_OE_BIT        = 10;

  localparam logic [15:0] FPW_LOW_RST       = 16'h0000;
  localparam logic [15:0] FPW_HIGH_RST      = 16'h0000;
  localparam logic [25:0] FPW_WORD_RST      = 26'h0000000;
  localparam logic [15:0] FPW_RD_UNMAPPED   = 16'h0000;

  // Host register access, one request per cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } fpw_req_t;

  // Word presented to the pulling logic
  typedef struct packed {
    logic        update;
    logic [25:0] word;
  } fpw_pull_t;

endpackage

// [hw/fpw_regs.sv]
`timescale 1ns/1ns
module fpw_regs
  import fpw_pkg::*;
(
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  // Host register port
  input  wire fpw_pkg::fpw_req_t  i_req,
  output logic [15:0]             o_rdata,
  output logic                    o_rvalid,
  // Output enable source: high selects the pin
  input  wire logic               i_oe_pin_mode,
  input  wire logic               i_oe_pin,
  // Pulling logic side
  output fpw_pkg::fpw_pull_t      o_pull,
  output logic                    o_out_en
);
  import fpw_pkg::*;

  logic [15:0]  low_reg;
  logic [9:0]   high_reg;
  logic         soft_oe_reg;
  logic [25:0]  word_reg;
  logic         update_reg;
  logic [15:0]  rdata_reg;
  logic         rvalid_reg;
  logic         out_en_reg;

  wire          wr_low     = i_req.wr && (i_req.addr == FPW_ADDR_LOW);
  wire          wr_high    = i_req.wr && (i_req.addr == FPW_ADDR_HIGH);
  wire          oe_wr_ok   = wr_high && !i_oe_pin_mode;
  wire [9:0]    high_next  = i_req.wdata[FPW_HIGH_W-1:0];
  // Low half read from the staged copy, high half from the new write
  wire [25:0]   word_next  = {high_next, low_reg};
  wire [15:0]   high_view  = {5'h00, soft_oe_reg, high_reg};
  wire [15:0]   rd_mux     = (i_req.addr == FPW_ADDR_LOW)  ? low_reg :
                             (i_req.addr == FPW_ADDR_HIGH) ? high_view :
                             FPW_RD_UNMAPPED;
  wire          oe_next    = i_oe_pin_mode ? i_oe_pin :
                             (oe_wr_ok ? i_req.wdata[FPW_OE_BIT] : soft_oe_reg);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_reg     <= FPW_LOW_RST;
      high_reg    <= FPW_HIGH_RST[9:0];
      soft_oe_reg <= FPW_HIGH_RST[FPW_OE_BIT];
      word_reg    <= FPW_WORD_RST;
      update_reg  <= 1'b0;
      rdata_reg   <= FPW_RD_UNMAPPED;
      rvalid_reg  <= 1'b0;
      out_en_reg  <= 1'b0;
    end else if (i_clk_en) begin
      update_reg <= wr_high;
      rvalid_reg <= i_req.rd;
      out_en_reg <= oe_next;
      if (i_req.rd) begin
        rdata_reg <= rd_mux;
      end
      if (wr_low) begin
        low_reg <= i_req.wdata; // staged only
      end
      if (wr_high) begin
        high_reg <= high_next;
        word_reg <= word_next;
      end
      if (oe_wr_ok) begin
        soft_oe_reg <= i_req.wdata[FPW_OE_BIT];
      end
    end
  end

  assign o_rdata      = rdata_reg;
  assign o_rvalid     = rvalid_reg;
  assign o_pull.word   = word_reg;
  assign o_pull.update = update_reg;
  assign o_out_en     = out_en_reg;

  // Low-only write never moves the applied word
  low_only_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_low && !wr_high) |=> $stable(word_reg))
    else $error("low write changed applied word");

  high_apply_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_high) |=> (word_reg == {$past(i_req.wdata[9:0]), $past(low_reg)})
    && update_reg)
    else $error("high write did not apply combined word");

  word_low_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    update_reg |-> word_reg[15:0] == low_reg)
    else $error("word low half differs from low register");

  word_high_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    update_reg |-> word_reg[25:16] == high_reg)
    else $error("word high half differs from high register");

  pin_ignore_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_oe_pin_mode) |=> $stable(soft_oe_reg))
    else $error("enable bit changed under pin control");

  soft_oe_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && oe_wr_ok) |=> soft_oe_reg == $past(i_req.wdata[10]))
    else $error("enable bit write not taken");

  high_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_req.rd && i_req.addr == FPW_ADDR_HIGH) |=>
    (o_rvalid && o_rdata[15:11] == 5'h00))
    else $error("unused high bits read nonzero");

  low_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_req.rd && !i_req.wr && i_req.addr == FPW_ADDR_LOW) |=>
    o_rdata == $past(low_reg))
    else $error("low register readback wrong");

  update_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !wr_high) |=> !update_reg)
    else $error("update pulse without high write");

  // Clock enable low freezes every register
  freeze_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    $stable(word_reg))
    else $error("applied word moved while clock enable low");

  freeze_low_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    $stable(low_reg))
    else $error("low register moved while clock enable low");

  freeze_high_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    $stable(high_reg))
    else $error("high register moved while clock enable low");

  freeze_oe_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    $stable(soft_oe_reg))
    else $error("enable bit moved while clock enable low");

  freeze_out_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    $stable(out_en_reg))
    else $error("output enable moved while clock enable low");

  freeze_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    ($stable(rdata_reg) && $stable(rvalid_reg)))
    else $error("read port moved while clock enable low");

  freeze_update_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clk_en |=>
    $stable(update_reg))
    else $error("update pulse moved while clock enable low");

  // Applied word and update pulse
  word_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !$stable(word_reg) |->
    ($past(i_clk_en) && $past(wr_high)))
    else $error("applied word changed without high write");

  update_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(update_reg) |->
    ($past(i_clk_en) && $past(wr_high)))
    else $error("update pulse rose without high write");

  word_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !wr_high) |=>
    $stable(word_reg))
    else $error("applied word changed between high writes");

  update_high_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_high) |=>
    o_pull.update)
    else $error("high write gave no update pulse");

  update_once_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && update_reg && !wr_high) |=>
    !update_reg)
    else $error("update pulse stood too long");

  low_no_update_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_low) |=>
    !update_reg)
    else $error("low write gave an update pulse");

  word_hi_src_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_high) |=>
    (word_reg[25:16] == $past(i_req.wdata[9:0])))
    else $error("word high half not from high write");

  word_lo_src_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_high) |=>
    (word_reg[15:0] == $past(low_reg)))
    else $error("word low half not from staged low");

  word_sign_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    update_reg |->
    (word_reg[25] == high_reg[9]))
    else $error("word sign differs from high register");

  // Register storage
  low_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_low) |=>
    (low_reg == $past(i_req.wdata)))
    else $error("low write not stored");

  high_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_high) |=>
    (high_reg == $past(i_req.wdata[9:0])))
    else $error("high write not stored");

  low_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !wr_low) |=>
    $stable(low_reg))
    else $error("low register changed without write");

  high_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !wr_high) |=>
    $stable(high_reg))
    else $error("high register changed without write");

  // Output enable
  oe_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !oe_wr_ok) |=>
    $stable(soft_oe_reg))
    else $error("enable bit changed without a taken write");

  pin_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_high && i_oe_pin_mode) |=>
    (soft_oe_reg == $past(soft_oe_reg)))
    else $error("pin mode high write moved enable bit");

  pin_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_oe_pin_mode) |=>
    (o_out_en == $past(i_oe_pin)))
    else $error("output enable not following pin");

  soft_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !i_oe_pin_mode) |=>
    (o_out_en == soft_oe_reg))
    else $error("output enable not following enable bit");

  soft_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && oe_wr_ok) |=>
    (o_out_en == $past(i_req.wdata[10])))
    else $error("written enable bit not driving output");

  soft_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !i_oe_pin_mode && !oe_wr_ok) |=>
    (o_out_en == $past(soft_oe_reg)))
    else $error("output enable differs from stored bit");

  // Read port
  rvalid_src_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_req.rd) |=>
    o_rvalid)
    else $error("read gave no valid pulse");

  rvalid_none_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !i_req.rd) |=>
    !o_rvalid)
    else $error("valid pulse without read");

  rvalid_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && o_rvalid && !i_req.rd) |=>
    !o_rvalid)
    else $error("valid pulse stood too long");

  high_value_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_req.rd && !i_req.wr && i_req.addr == FPW_ADDR_HIGH) |=>
    (o_rdata == {5'h00, $past(soft_oe_reg), $past(high_reg)}))
    else $error("high register readback wrong");

  unmapped_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_req.rd && i_req.addr != FPW_ADDR_LOW && i_req.addr != FPW_ADDR_HIGH) |=>
    (o_rdata == FPW_RD_UNMAPPED))
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !i_req.rd) |=>
    $stable(rdata_reg))
    else $error("read data changed without read");

  read_old_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_req.rd && wr_low) |=>
    (o_rdata == $past(low_reg)))
    else $error("read with write did not return old value");

endmodule // fpw_regs

// [tb/fpw_host.sv]
`timescale 1ns/1ns
module fpw_host
  import fpw_pkg::*;
(
  input  wire logic         i_core_clk,
  output fpw_pkg::fpw_req_t o_req
);
  initial o_req = '0;
  // Request held for one sampling edge, then lines scrambled
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // fpw_host

// [tb/fpw_regs_bench.sv]
`timescale 1ns/1ns
module fpw_regs_bench;
  import fpw_pkg::*;
  logic i_core_clk = 0, i_rst_n = 0, oe_mode = 0, oe_pin = 0, rvalid, out_en;
  logic clk_en = 1;
  logic [25:0] w;
  fpw_req_t req;
  fpw_pull_t pull;
  logic [15:0] rdata, lo, hi, hreg;
  logic [31:0] seed = 32'hB21135A6;
  logic [25:0] q_rd[$], q_wd[$];
  int n_errors = 0, total_checks = 0;
  always #25 i_core_clk = ~i_core_clk;
  fpw_host fpw_host_i (.i_core_clk(i_core_clk), .o_req(req));
  fpw_regs fpw_regs_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
    .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .i_oe_pin_mode(oe_mode),
    .i_oe_pin(oe_pin), .o_pull(pull), .o_out_en(out_en));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    q_rd.push_back({10'h0, e});
    fpw_host_i.access(1'b0, a, 16'h0);
  endtask
  // Unexpected results meet an unknown note and fail
  always @(negedge i_core_clk) begin
    if (rvalid === 1'b1) chk({10'h0, rdata}, q_rd.size() ? q_rd.pop_front() : 'x);
    if (pull.update === 1'b1) chk(pull.word, q_wd.size() ? q_wd.pop_front() : 'x);
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk) i_rst_n = 1;
    chk(pull.word, FPW_WORD_RST);
    chk({25'h0, out_en}, 26'h0);
    rd(FPW_ADDR_LOW, FPW_LOW_RST);
    rd(FPW_ADDR_HIGH, FPW_HIGH_RST);
    $display("reset test done");
    hreg = 16'h0;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      lo = seed[15:0];
      seed = lfsr(seed);
      hi = seed[31:16];
      oe_mode = (i > 3);
      oe_pin = seed[3];
      hreg = oe_mode ? {5'h0, hreg[10], hi[9:0]} : {5'h0, hi[10:0]};
      fpw_host_i.access(1'b1, FPW_ADDR_LOW, lo);
      repeat (3) @(negedge i_core_clk);
      q_wd.push_back({hi[9:0], lo});
      fpw_host_i.access(1'b1, FPW_ADDR_HIGH, hi);
      rd(FPW_ADDR_HIGH, hreg);
      rd(FPW_ADDR_LOW, lo);
      chk({25'h0, out_en}, {25'h0, oe_mode ? oe_pin : hreg[10]});
      $display("update test %0d done", i);
      repeat (530) @(negedge i_core_clk);
    end
    oe_mode = 0;
    w = 26'((longint'(90) * 33554431 * 2 + 200) / 400);
    lo = w[15:0];
    hreg = {5'h0, 1'b1, w[25:16]};
    fpw_host_i.access(1'b1, FPW_ADDR_LOW, lo);
    q_wd.push_back(w);
    fpw_host_i.access(1'b1, FPW_ADDR_HIGH, hreg);
    rd(FPW_ADDR_HIGH, hreg);
    chk({25'h0, out_en}, 26'h1);
    $display("computed word test done");
    repeat (530) @(negedge i_core_clk);
    clk_en = 0;
    fpw_host_i.access(1'b1, FPW_ADDR_HIGH, 16'h0000);
    clk_en = 1;
    rd(FPW_ADDR_HIGH, hreg);
    chk(pull.word, w);
    chk({25'h0, out_en}, 26'h1);
    $display("clock enable test done");
    fpw_host_i.access(1'b1, 8'h05, 16'hFFFF);
    rd(8'h05, FPW_RD_UNMAPPED);
    rd(FPW_ADDR_LOW, lo);
    repeat (4) @(negedge i_core_clk);
    chk(26'(q_rd.size() + q_wd.size()), 26'h0);
    $display("unmapped test done");
    close_out();
  end
endmodule // fpw_regs_bench
